// ---- gp_routing_consts.svh ----
// Offsets, field layout, reset values and widths of the output latch and routing logic
`ifndef GP_ROUTING_CONSTS_SVH
`define GP_ROUTING_CONSTS_SVH

// ==========================================================
// Bus geometry
`define ADDR_WIDTH 12
`define DATA_WIDTH 32

// ==========================================================
// Register indices and byte addresses
`define GPO_INDEX 12'h08b
`define ROUTE_INDEX 12'h08c
`define GPO_ADDR (`GPO_INDEX << 2)
`define ROUTE_ADDR (`ROUTE_INDEX << 2)

// ==========================================================
// Output latch layout
`define GPO_WIDTH 5
`define GPO_RESET 5'h00

// ==========================================================
// Routing register layout: seven 4-bit fields, bits 31:28 read zero
`define ROUTE_WIDTH 28
`define ROUTE_RESET 28'h0001000
`define FIELD_WIDTH 4
`define TERM_COUNT 7

`endif

// ---- gp_routing_pkg.sv ----
// Types shared by the output latch and terminal routing logic
package gp_routing_pkg;

	// ==========================================================
	// Internal signals that may be routed onto a terminal
	typedef struct packed {
		logic [15:0] irq;
		logic clkrun;
		logic serialized_interrupt_stream;
		logic legacy_dma_grant;
		logic legacy_dma_request;
		logic pci_lock;
		logic video_port_status;
		logic card_audio_pwm;
		logic firewire_activity_led;
		logic socket_led_1;
		logic socket_led_2;
		logic combined_socket_led;
		logic ring_indicate_output;
		logic test_multiplexer;
		logic event_output;
		logic pci_intb;
		logic pci_intc;
	} internal_sources_t;

	// ==========================================================
	// Per-terminal drive decision
	typedef struct packed {
		logic value;
		logic drive;
	} drive_t;

endpackage : gp_routing_pkg

// ---- pin_sync.sv ----
// Two-flop synchroniser for terminal input levels
`timescale 1ns/1ns
module pin_sync #(
	parameter int WIDTH = 7
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	input wire logic pclk_en,
	// Levels
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] stage;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stage <= '0;
			sync_out <= '0;
		end else if (pclk_en) begin
			stage <= async_in;
			sync_out <= stage;
		end
	end

endmodule : pin_sync

// ---- gp_routing.sv ----
// General output latch and multifunction terminal routing, APB slave
// How it works
// - Five output bits at 0x8B, read/write; bits 4, 3, 2, 0 can drive terminals 5, 4, 2, 0; bit 1 drives no terminal.
// - Output register bits 7:5 read zero; writes to them ignored.
// - Output register resets to 0x00, cleared only by the global reset pin.
// - Routing register at 0x8C defaults 0x00001000; EEPROM load may replace it.
// - Routing bits 31:28 are read-only zero.
// - Field 27:24 picks terminal 6: clock-run, IRQ2, IRQ4-6, IRQ8-15.
// - Field 23:20 picks terminal 5 source from its fourteen listed codes.
// - Field 19:16 picks terminal 4 source; code 1010 reserved.
// - Field 15:12 picks terminal 3: serial IRQ stream, IRQ2, IRQ4-6, IRQ8-15.
// - Field 11:8 picks terminal 2 source; 1111 is IRQ7.
// - Field 7:4 picks terminal 1 from its legible codes.
// - Field 3:0 picks terminal 0 from its legible codes.
// - Routing fields clear only on global reset, kept across other resets.
//
// Our own choice: register access over APB.
`timescale 1ns/1ns
`include "gp_routing_consts.svh"
module gp_routing (
	// Clock, bus reset, clock enable
	input wire logic pclk,
	input wire logic presetn,
	input wire logic pclk_en,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [`ADDR_WIDTH-1:0] paddr,
	input wire logic [`DATA_WIDTH-1:0] pwdata,
	output logic [`DATA_WIDTH-1:0] prdata,
	output logic pready,
	output logic pslverr,
	// Global reset and EEPROM preload
	input wire logic global_reset_n,
	input wire logic eeprom_load_valid,
	input wire logic [`ROUTE_WIDTH-1:0] eeprom_load_data,
	// Internal signal sources
	input wire gp_routing_pkg::internal_sources_t sources,
	// Multifunction terminals
	input wire logic [`TERM_COUNT-1:0] term_in,
	output logic [`TERM_COUNT-1:0] term_out,
	output logic [`TERM_COUNT-1:0] term_oe_n,
	// General input levels seen on terminals 5, 4, 2 when routed as inputs; bits 1 and 0 stay zero
	output logic [`GPO_WIDTH-1:0] general_input
);

	// ==========================================================
	// Declarations
	logic [`GPO_WIDTH-1:0] gpo;
	logic [`GPO_WIDTH-1:0] next_gpo;
	logic [`ROUTE_WIDTH-1:0] route;
	logic [`ROUTE_WIDTH-1:0] next_route;
	logic [`DATA_WIDTH-1:0] next_prdata;
	logic next_pready;
	logic next_pslverr;
	logic [`TERM_COUNT-1:0] next_term_out;
	logic [`TERM_COUNT-1:0] next_term_oe_n;
	logic [`GPO_WIDTH-1:0] next_general_input;
	logic [`TERM_COUNT-1:0] term_sync;
	logic write_done;

	// ==========================================================
	// Functions
	function automatic logic is_mapped(input logic [`ADDR_WIDTH-1:0] addr);
		return (addr == `GPO_ADDR) || (addr == `ROUTE_ADDR);
	endfunction : is_mapped

	function automatic gp_routing_pkg::drive_t route_terminal(
		input logic [2:0] term,
		input logic [3:0] code,
		input gp_routing_pkg::internal_sources_t s,
		input logic [`GPO_WIDTH-1:0] g
	);
		gp_routing_pkg::drive_t d;
		d.value = 1'b0;
		d.drive = 1'b1;
		if (term == 3'h6 || term == 3'h3) begin
			// Interrupt-heavy terminals
			case (code)
				4'h1: d.value = (term == 3'h6) ? s.clkrun : s.serialized_interrupt_stream;
				4'h2, 4'h4, 4'h5, 4'h6: d.value = s.irq[code];
				4'h8, 4'h9, 4'ha, 4'hb, 4'hc, 4'hd, 4'he, 4'hf: d.value = s.irq[code];
				default: d.drive = 1'b0;
			endcase
		end else begin
			case (code)
				4'h1: begin
					case (term)
						3'h5: d.value = g[4];
						3'h4: d.value = g[3];
						3'h2: d.value = g[2];
						3'h0: d.value = g[0];
						default: d.drive = 1'b0;
					endcase
				end
				4'h2: begin
					case (term)
						3'h5: d.value = s.legacy_dma_grant;
						3'h4: d.value = s.pci_lock;
						3'h2: d.value = s.legacy_dma_request;
						3'h1: d.value = s.pci_intb;
						default: d.drive = 1'b0;
					endcase
				end
				4'h4, 4'h5: begin
					d.value = s.irq[code];
					d.drive = (term == 3'h5) || (term == 3'h4) || (term == 3'h2);
				end
				4'h6: begin
					d.value = s.video_port_status;
					d.drive = (term != 3'h0);
				end
				4'h8: d.value = s.card_audio_pwm;
				4'h9: d.value = s.irq[9];
				4'ha: begin
					d.value = s.irq[10];
					d.drive = (term != 3'h4);
				end
				4'hb: begin
					case (term)
						3'h5: d.value = s.firewire_activity_led;
						3'h4: d.value = s.irq[11];
						3'h2: d.value = s.pci_intc;
						default: d.drive = 1'b0;
					endcase
				end
				4'hc: begin
					if (term == 3'h4 || term == 3'h2) begin
						d.value = s.ring_indicate_output;
					end else begin
						d.value = s.socket_led_1;
					end
				end
				4'hd: begin
					case (term)
						3'h5, 3'h4: d.value = s.combined_socket_led;
						3'h2: d.value = s.test_multiplexer;
						default: d.value = s.socket_led_2;
					endcase
				end
				4'he: d.value = s.event_output;
				4'hf: d.value = (term == 3'h2) ? s.irq[7] : s.irq[15];
				default: d.drive = 1'b0;
			endcase
		end
		if (!d.drive) begin
			d.value = 1'b0;
		end
		return d;
	endfunction : route_terminal

	// ==========================================================
	// APB answer: one wait-free access phase after each setup
	assign write_done = pclk_en && psel && penable && pready && pwrite;

	always_comb begin
		next_pready = pready;
		next_prdata = prdata;
		next_pslverr = pslverr;
		if (pclk_en) begin
			next_pready = psel && !penable && !pready;
			if (psel && !penable) begin
				next_pslverr = !is_mapped(paddr);
				if (paddr == `GPO_ADDR) begin
					next_prdata = {{(`DATA_WIDTH-`GPO_WIDTH){1'b0}}, gpo};
				end else if (paddr == `ROUTE_ADDR) begin
					next_prdata = {{(`DATA_WIDTH-`ROUTE_WIDTH){1'b0}}, route};
				end else begin
					next_prdata = '0;
				end
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			prdata <= '0;
			pslverr <= 1'b0;
		end else begin
			pready <= next_pready;
			prdata <= next_prdata;
			pslverr <= next_pslverr;
		end
	end

	// ==========================================================
	// Output latch and routing register, global reset only
	always_comb begin
		next_gpo = gpo;
		next_route = route;
		if (write_done && paddr == `GPO_ADDR) begin
			next_gpo = pwdata[`GPO_WIDTH-1:0];
		end
		if (write_done && paddr == `ROUTE_ADDR) begin
			next_route = pwdata[`ROUTE_WIDTH-1:0];
		end
		// EEPROM preload takes precedence over a same-cycle write
		if (pclk_en && eeprom_load_valid) begin
			next_route = eeprom_load_data;
		end
	end

	always_ff @(posedge pclk or negedge global_reset_n) begin
		if (!global_reset_n) begin
			gpo <= `GPO_RESET;
			route <= `ROUTE_RESET;
		end else begin
			gpo <= next_gpo;
			route <= next_route;
		end
	end

	// ==========================================================
	// Terminal input synchroniser
	pin_sync #(
		.WIDTH(`TERM_COUNT)
	) u_term_sync (
		.pclk(pclk),
		.presetn(presetn),
		.pclk_en(pclk_en),
		.async_in(term_in),
		.sync_out(term_sync)
	);

	// ==========================================================
	// Terminal drive and general input capture
	always_comb begin
		gp_routing_pkg::drive_t d;
		d = '0;
		next_term_out = term_out;
		next_term_oe_n = term_oe_n;
		next_general_input = general_input;
		if (pclk_en) begin
			for (int k = 0; k < `TERM_COUNT; k++) begin
				d = route_terminal(3'(k), route[k*`FIELD_WIDTH +: `FIELD_WIDTH], sources, gpo);
				next_term_out[k] = d.value;
				next_term_oe_n[k] = !d.drive;
			end
			// Inputs read only when their field selects the input code
			next_general_input = '0;
			next_general_input[4] = (route[23:20] == 4'h0) && term_sync[5];
			next_general_input[3] = (route[19:16] == 4'h0) && term_sync[4];
			next_general_input[2] = (route[11:8] == 4'h0) && term_sync[2];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			term_out <= '0;
			term_oe_n <= '1;
			general_input <= '0;
		end else begin
			term_out <= next_term_out;
			term_oe_n <= next_term_oe_n;
			general_input <= next_general_input;
		end
	end

	// ==========================================================
	// Assertions
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn || !global_reset_n);

	AST_GPO_WRITE: assert property (
		write_done && paddr == `GPO_ADDR |=> gpo == $past(pwdata[`GPO_WIDTH-1:0])
	) else $error("output latch did not take written value");

	AST_GPO_ON_PIN: assert property (
		pclk_en && route[23:20] == 4'h1 |=> !term_oe_n[5] && term_out[5] == $past(gpo[4])
	) else $error("terminal 5 does not show latch bit 4");

	AST_GPO_HIGH_ZERO: assert property (
		pready && paddr == `GPO_ADDR |-> prdata[`DATA_WIDTH-1:`GPO_WIDTH] == '0
	) else $error("output register upper bits not zero");

	AST_LATCH_RESET: assert property (
		@(posedge pclk) disable iff (1'b0)
		!global_reset_n |-> gpo == `GPO_RESET && route == `ROUTE_RESET
	) else $error("global reset did not restore defaults");

	AST_EEPROM_LOAD: assert property (
		pclk_en && eeprom_load_valid |=> route == $past(eeprom_load_data)
	) else $error("EEPROM value not loaded");

	AST_ROUTE_TOP_ZERO: assert property (
		pready && paddr == `ROUTE_ADDR |-> prdata[`DATA_WIDTH-1:`ROUTE_WIDTH] == '0 && prdata[27:0] == route
	) else $error("routing read back wrong");

	AST_T6_CLKRUN: assert property (
		pclk_en && route[27:24] == 4'h1 |=> !term_oe_n[6] && term_out[6] == $past(sources.clkrun)
	) else $error("terminal 6 not carrying clock-run");

	AST_T3_SERIAL: assert property (
		pclk_en && route[15:12] == 4'h1 |=> term_out[3] == $past(sources.serialized_interrupt_stream)
	) else $error("terminal 3 not carrying serial IRQ");

	AST_T2_IRQ7: assert property (
		pclk_en && route[11:8] == 4'hf |=> term_out[2] == $past(sources.irq[7])
	) else $error("terminal 2 not carrying IRQ7");

	AST_ROUTE_KEPT: assert property (
		@(posedge pclk) disable iff (!global_reset_n)
		!presetn && !(pclk_en && eeprom_load_valid) |=> $stable(route)
	) else $error("routing changed under bus reset");

	AST_RESERVED_FLOAT: assert property (
		pclk_en && (route[27:24] == 4'h0 || route[19:16] == 4'ha) |=>
			(term_oe_n[6] || $past(route[27:24]) != 4'h0) && (term_oe_n[4] || $past(route[19:16]) != 4'ha)
	) else $error("reserved code drives terminal");

	COV_GPO_WRITE: cover property (write_done && paddr == `GPO_ADDR);
	COV_ROUTE_WRITE: cover property (write_done && paddr == `ROUTE_ADDR);
	COV_EEPROM: cover property (pclk_en && eeprom_load_valid);
	COV_BAD_ADDR: cover property (pready && pslverr);

endmodule : gp_routing

// ---- board_pins.sv ----
// Board model: resolves each multifunction terminal wire
`timescale 1ns/1ns
module board_pins (
	// Terminal side of the block
	input wire logic [6:0] term_out,
	input wire logic [6:0] term_oe_n,
	// Wire level seen back by the block
	output logic [6:0] term_in,
	// Level the board puts on a pin the block leaves free
	input wire logic [6:0] ext_level
);
	// Driven pins read their own value, free pins the board level
	assign term_in = (term_out & ~term_oe_n) | (ext_level & term_oe_n);
endmodule : board_pins

// ---- gp_routing_test.sv ----
// Self-checking bench for the output latch and terminal routing
`timescale 1ns/1ns
`include "gp_routing_consts.svh"
module gp_routing_test;
	logic pclk = 1'b0;
	logic presetn = 1'b1;
	logic global_reset_n = 1'b1;
	logic pclk_en = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [`ADDR_WIDTH-1:0] paddr = '0;
	logic [`DATA_WIDTH-1:0] pwdata = '0;
	logic [`DATA_WIDTH-1:0] prdata;
	logic pready;
	logic pslverr;
	logic eeprom_load_valid = 1'b0;
	logic [`ROUTE_WIDTH-1:0] eeprom_load_data = '0;
	gp_routing_pkg::internal_sources_t src = 32'ha5c3_5a3c;
	logic [6:0] term_in;
	logic [6:0] term_out;
	logic [6:0] term_oe_n;
	logic [6:0] ext_level = 7'h00;
	logic [4:0] general_input;
	logic [31:0] rd_data;
	logic rd_err;
	int n_mismatch = 0;
	int checked = 0;

	always #50 pclk = ~pclk;

	gp_routing dut (.pclk(pclk), .presetn(presetn), .pclk_en(pclk_en), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.global_reset_n(global_reset_n), .eeprom_load_valid(eeprom_load_valid),
		.eeprom_load_data(eeprom_load_data), .sources(src), .term_in(term_in), .term_out(term_out),
		.term_oe_n(term_oe_n), .general_input(general_input));

	board_pins pins (.term_out(term_out), .term_oe_n(term_oe_n), .term_in(term_in), .ext_level(ext_level));

	// ==========================================================
	// Bus cycles and comparison
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check

	task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wdata);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= addr;
		pwdata <= wdata;
		@(posedge pclk);
		penable <= 1'b1;
		while (pready !== 1'b1 && n < 20) begin
			@(posedge pclk);
			n++;
		end
		if (n >= 20) begin
			n_mismatch++;
			$display("Error at %0t: no bus answer", $time);
		end
		rd_data = prdata;
		rd_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// ==========================================================
	// Scenarios
	task automatic test_defaults;
		apb(1'b0, `GPO_ADDR, '0);
		check(rd_data, 32'h0000_0000);
		apb(1'b0, `ROUTE_ADDR, '0);
		check(rd_data, 32'h0000_1000);
		check({term_oe_n[3], term_out[3]}, {1'b0, src.serialized_interrupt_stream});
		check(term_oe_n[6], 1'b1);
	endtask : test_defaults

	task automatic test_latch_and_routing;
		apb(1'b1, `GPO_ADDR, 32'hffff_ffef);
		apb(1'b0, `GPO_ADDR, '0);
		check(rd_data, 32'h0000_000f);
		apb(1'b1, `GPO_ADDR, 32'h0000_0011);
		apb(1'b1, `ROUTE_ADDR, 32'hff1a_1021);
		apb(1'b0, `ROUTE_ADDR, '0);
		check(rd_data, 32'h0f1a_1021);
		ext_level <= 7'h0c;
		repeat (5) @(posedge pclk);
		check({term_oe_n[6], term_out[6]}, {1'b0, src.irq[15]});
		check({term_oe_n[5], term_out[5]}, 2'b01);
		check({term_oe_n[0], term_out[0]}, 2'b01);
		check({term_oe_n[4], general_input[3]}, 2'b10);
		check({term_oe_n[2], general_input[2]}, 2'b11);
		check({term_oe_n[1], term_out[1]}, {1'b0, src.pci_intb});
	endtask : test_latch_and_routing

	task automatic test_irq_codes;
		int codes[11] = '{2, 4, 5, 6, 8, 9, 10, 11, 12, 13, 14};
		apb(1'b1, `ROUTE_ADDR, 32'h0100_0000);
		repeat (2) @(posedge pclk);
		check({term_oe_n[6], term_out[6]}, {1'b0, src.clkrun});
		foreach (codes[i]) begin
			apb(1'b1, `ROUTE_ADDR, (32'(codes[i]) << 24) | (32'(codes[i]) << 12));
			repeat (2) @(posedge pclk);
			check({term_oe_n[6], term_out[6]}, {1'b0, src.irq[codes[i]]});
			check({term_oe_n[3], term_out[3]}, {1'b0, src.irq[codes[i]]});
		end
		apb(1'b1, `ROUTE_ADDR, 32'h00bc_0fd0);
		repeat (2) @(posedge pclk);
		check({term_oe_n[2], term_out[2]}, {1'b0, src.irq[7]});
		check({term_oe_n[4], term_out[4]}, {1'b0, src.ring_indicate_output});
		check({term_oe_n[5], term_out[5]}, {1'b0, src.firewire_activity_led});
		check({term_oe_n[1], term_out[1]}, {1'b0, src.socket_led_2});
		check({term_oe_n[6], term_oe_n[3], term_oe_n[0]}, 3'b111);
	endtask : test_irq_codes

	task automatic test_resets;
		apb(1'b1, `GPO_ADDR, 32'h0000_000a);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, `GPO_ADDR, '0);
		check(rd_data, 32'h0000_000a);
		apb(1'b0, `ROUTE_ADDR, '0);
		check(rd_data, 32'h00bc_0fd0);
		global_reset_n <= 1'b0;
		repeat (2) @(posedge pclk);
		global_reset_n <= 1'b1;
		apb(1'b0, `GPO_ADDR, '0);
		check(rd_data, 32'h0000_0000);
		apb(1'b0, `ROUTE_ADDR, '0);
		check(rd_data, 32'h0000_1000);
	endtask : test_resets

	task automatic test_eeprom_and_unmapped;
		@(posedge pclk);
		eeprom_load_valid <= 1'b1;
		eeprom_load_data <= 28'h39c_5b37;
		@(posedge pclk);
		eeprom_load_valid <= 1'b0;
		apb(1'b0, `ROUTE_ADDR, '0);
		check(rd_data, 32'h039c_5b37);
		// Load pulse while the clock enable is low must be ignored
		pclk_en <= 1'b0;
		eeprom_load_valid <= 1'b1;
		eeprom_load_data <= 28'h123_4567;
		@(posedge pclk);
		pclk_en <= 1'b1;
		eeprom_load_valid <= 1'b0;
		apb(1'b0, `ROUTE_ADDR, '0);
		check(rd_data, 32'h039c_5b37);
		apb(1'b1, 12'h100, 32'hffff_ffff);
		check({rd_err, rd_data}, {1'b1, 32'h0});
	endtask : test_eeprom_and_unmapped

	// ==========================================================
	// Verdict and run control
	task automatic results;
		$display("Comparisons %0d, mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : results

	initial begin
		repeat (3000) @(posedge pclk);
		n_mismatch++;
		$display("Error at %0t: run timed out", $time);
		results;
	end

	initial begin
		// Real falling edge at time zero so both resets act before the first clock
		presetn <= 1'b0;
		global_reset_n <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		global_reset_n <= 1'b1;
		test_defaults;
		test_latch_and_routing;
		test_irq_codes;
		test_resets;
		test_eeprom_and_unmapped;
		results;
	end
endmodule : gp_routing_test
